// file: plfg_pkg.sv
// package: constants and carrier types for the phy loopback, frame generator and checker block
package plfg_pkg;
  localparam int DATA_W = 4;
  localparam int CNT_W = 16;
  localparam int FRM_CNT_W = 32;
  localparam int LEN_W = 16;
  localparam int NUM_ERR = 9;
  // error counter slots
  localparam int E_CRC = 0;
  localparam int E_LEN = 1;
  localparam int E_ALIGN = 2;
  localparam int E_SYM = 3;
  localparam int E_OVER = 4;
  localparam int E_UNDER = 5;
  localparam int E_ODD_FRM = 6;
  localparam int E_ODD_PRE = 7;
  localparam int E_FALSE_CAR = 8;
  localparam logic [1:0] PAY_RANDOM = 2'h0;
  localparam logic [1:0] PAY_ONES = 2'h1;
  localparam logic [1:0] PAY_ZEROS = 2'h2;
  localparam logic [1:0] PAY_INCR = 2'h3;
  localparam logic [15:0] LFSR_SEED = 16'hace1;
  localparam logic [15:0] LFSR_TAPS = 16'hb400;
  localparam logic SRC_PHY = 1'b0;
  localparam logic SRC_MAC = 1'b1;

  // nibble stream with frame delimiting
  typedef struct packed {
    logic valid;
    logic last;
    logic [DATA_W-1:0] data;
  } plfg_stream_t;

  // per-frame status from the receive decoder
  typedef struct packed {
    logic frame_end;
    logic crc_err;
    logic len_err;
    logic align_err;
    logic sym_err;
    logic oversize;
    logic undersize;
    logic odd_nibble;
    logic odd_preamble;
    logic bad_ssd;
  } plfg_rx_status_t;

  // loopback controls
  typedef struct packed {
    logic pma_local_echo_enable;
    logic pcs_echo_enable;
    logic mac_side_echo_enable;
    logic mac_side_tx_suppress;
    logic mac_side_remote_echo_enable;
    logic mac_side_rx_suppress;
    logic mac_echo_enable;
  } plfg_loop_ctrl_t;

  typedef struct packed {
    logic [1:0] payload_type;
    logic [LEN_W-1:0] frame_length;
    logic [CNT_W-1:0] frame_number;
  } plfg_gen_cfg_t;
endpackage

// file: plfg_top.sv
// module: per-phy loopback paths, frame generator and frame checker
`timescale 1ns/1ps
module plfg_top #(
  parameter int CNT_W = plfg_pkg::CNT_W,
  parameter int FRM_CNT_W = plfg_pkg::FRM_CNT_W
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire plfg_pkg::plfg_loop_ctrl_t loop_ctrl,
  input wire logic link_up,
  input wire logic diag_clock_enable,
  input wire plfg_pkg::plfg_gen_cfg_t gen_cfg,
  input wire logic frame_gen_enable,
  output logic frame_gen_done,
  input wire logic frame_check_enable,
  input wire logic frame_check_source_select,
  input wire logic rx_error_count_read,
  output logic [CNT_W-1:0] rx_error_count,
  output logic [FRM_CNT_W/2-1:0] frame_count_high,
  output logic [FRM_CNT_W/2-1:0] frame_count_low,
  output logic [plfg_pkg::NUM_ERR*CNT_W-1:0] err_count_snap,
  input wire plfg_pkg::plfg_stream_t mac_tx_in,
  output plfg_pkg::plfg_stream_t mac_rx_out,
  output plfg_pkg::plfg_stream_t core_tx_out,
  input wire plfg_pkg::plfg_stream_t core_rx_in,
  input wire plfg_pkg::plfg_rx_status_t core_rx_status,
  input wire plfg_pkg::plfg_rx_status_t mac_rx_status,
  output logic mdi_tx_enable,
  output logic pma_echo_mode,
  output logic pcs_echo_mode
);
  // refuse counter widths that the snapshot split and the saturation logic cannot serve
  if (CNT_W < 2 || CNT_W > 32 || FRM_CNT_W < 2 || FRM_CNT_W % 2 != 0) begin : g_bad_width
    $error("plfg_top: unsupported counter width");
  end

  typedef enum logic [2:0] {
    GEN_IDLE = 3'b001,
    GEN_SEND = 3'b010,
    GEN_DONE = 3'b100
  } plfg_gen_state_t;

  // ---------------- frame generator ----------------
  plfg_gen_state_t gen_state, next_gen_state;
  logic [plfg_pkg::LEN_W-1:0] nib_cnt, next_nib_cnt;
  logic [CNT_W-1:0] frm_left, next_frm_left;
  logic [15:0] lfsr, next_lfsr;
  logic gen_en_d, next_gen_en_d;
  logic done, next_done;
  logic gen_start;
  logic gen_active;
  plfg_pkg::plfg_stream_t gen_strm;

  assign gen_start = frame_gen_enable && !gen_en_d && diag_clock_enable;
  assign gen_active = frame_gen_enable;

  always_comb begin
    next_gen_state = gen_state;
    next_nib_cnt = nib_cnt;
    next_frm_left = frm_left;
    next_lfsr = lfsr;
    next_gen_en_d = frame_gen_enable;
    next_done = done;
    gen_strm = '0;
    case (gen_state)
      GEN_IDLE: begin
        if (gen_start) begin
          next_done = 1'b0;
          next_nib_cnt = '0;
          next_frm_left = CNT_W'(gen_cfg.frame_number);
          next_lfsr = plfg_pkg::LFSR_SEED;
          if (gen_cfg.frame_number == '0 || gen_cfg.frame_length == '0) begin
            next_gen_state = GEN_DONE;
          end else begin
            next_gen_state = GEN_SEND;
          end
        end
      end
      GEN_SEND: begin
        if (!frame_gen_enable) begin
          next_gen_state = GEN_IDLE;
        end else if (diag_clock_enable) begin
          gen_strm.valid = 1'b1;
          case (gen_cfg.payload_type)
            plfg_pkg::PAY_RANDOM: gen_strm.data = lfsr[plfg_pkg::DATA_W-1:0];
            plfg_pkg::PAY_ONES: gen_strm.data = '1;
            plfg_pkg::PAY_ZEROS: gen_strm.data = '0;
            default: gen_strm.data = nib_cnt[plfg_pkg::DATA_W-1:0];
          endcase
          next_lfsr = lfsr[0] ? ((lfsr >> 1) ^ plfg_pkg::LFSR_TAPS) : (lfsr >> 1);
          if (nib_cnt == gen_cfg.frame_length - 1'b1) begin
            gen_strm.last = 1'b1;
            next_nib_cnt = '0;
            next_frm_left = frm_left - 1'b1;
            if (frm_left == CNT_W'(1)) begin
              next_gen_state = GEN_DONE;
            end
          end else begin
            next_nib_cnt = nib_cnt + 1'b1;
          end
        end
      end
      GEN_DONE: begin
        next_done = 1'b1;
        next_gen_state = GEN_IDLE;
      end
      default: next_gen_state = GEN_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gen_state <= GEN_IDLE;
      nib_cnt <= '0;
      frm_left <= '0;
      lfsr <= plfg_pkg::LFSR_SEED;
      gen_en_d <= 1'b0;
      done <= 1'b0;
    end else begin
      gen_state <= next_gen_state;
      nib_cnt <= next_nib_cnt;
      frm_left <= next_frm_left;
      lfsr <= next_lfsr;
      gen_en_d <= next_gen_en_d;
      done <= next_done;
    end
  end
  assign frame_gen_done = done;

  // ---------------- loopback datapaths ----------------
  plfg_pkg::plfg_stream_t next_core_tx, next_mac_rx;
  logic next_mdi_en;
  logic next_pma_mode, next_pcs_mode;
  logic mac_loop, remote_loop;

  assign mac_loop = loop_ctrl.mac_side_echo_enable || loop_ctrl.mac_echo_enable;
  assign remote_loop = loop_ctrl.mac_side_remote_echo_enable && link_up;

  always_comb begin
    next_core_tx = mac_tx_in;
    next_mac_rx = core_rx_in;
    if (gen_active) begin
      next_core_tx = gen_strm;
    end else if (remote_loop) begin
      next_core_tx = core_rx_in;
    end else if (mac_loop && (loop_ctrl.mac_side_tx_suppress || loop_ctrl.mac_echo_enable)) begin
      next_core_tx = '0;
    end
    if (mac_loop) begin
      next_mac_rx = mac_tx_in;
    end else if (remote_loop && loop_ctrl.mac_side_rx_suppress) begin
      next_mac_rx = '0;
    end
    next_mdi_en = !loop_ctrl.pcs_echo_enable;
    next_pma_mode = loop_ctrl.pma_local_echo_enable;
    next_pcs_mode = loop_ctrl.pcs_echo_enable;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      core_tx_out <= '0;
      mac_rx_out <= '0;
      mdi_tx_enable <= 1'b0;
      pma_echo_mode <= 1'b0;
      pcs_echo_mode <= 1'b0;
    end else begin
      core_tx_out <= next_core_tx;
      mac_rx_out <= next_mac_rx;
      mdi_tx_enable <= next_mdi_en;
      pma_echo_mode <= next_pma_mode;
      pcs_echo_mode <= next_pcs_mode;
    end
  end

  // ---------------- frame checker ----------------
  localparam int NUM_E = plfg_pkg::NUM_ERR;
  plfg_pkg::plfg_rx_status_t chk_st;
  logic [NUM_E-1:0] ev;
  logic [FRM_CNT_W-1:0] frm_cnt, next_frm_cnt, frm_snap, next_frm_snap;
  logic [CNT_W-1:0] err_cnt [NUM_E];
  logic [CNT_W-1:0] next_err_cnt [NUM_E];
  logic [CNT_W-1:0] err_snap [NUM_E];
  logic [CNT_W-1:0] next_err_snap [NUM_E];
  logic frame_check_enable_d, next_frame_check_enable_d;
  logic fc_start;

  assign chk_st = (frame_check_source_select == plfg_pkg::SRC_MAC) ? mac_rx_status
                                                                  : core_rx_status;
  assign fc_start = frame_check_enable && !frame_check_enable_d;
  assign next_frame_check_enable_d = frame_check_enable;

  assign ev[plfg_pkg::E_CRC] = chk_st.frame_end && chk_st.crc_err;
  assign ev[plfg_pkg::E_LEN] = chk_st.frame_end && chk_st.len_err;
  assign ev[plfg_pkg::E_ALIGN] = chk_st.frame_end && chk_st.align_err;
  assign ev[plfg_pkg::E_SYM] = chk_st.frame_end && chk_st.sym_err;
  assign ev[plfg_pkg::E_OVER] = chk_st.frame_end && chk_st.oversize;
  assign ev[plfg_pkg::E_UNDER] = chk_st.frame_end && chk_st.undersize;
  assign ev[plfg_pkg::E_ODD_FRM] = chk_st.frame_end && chk_st.odd_nibble;
  assign ev[plfg_pkg::E_ODD_PRE] = chk_st.frame_end && chk_st.odd_preamble;
  assign ev[plfg_pkg::E_FALSE_CAR] = chk_st.bad_ssd;

  always_comb begin
    next_frm_cnt = frm_cnt;
    next_frm_snap = frm_snap;
    if (fc_start) begin
      next_frm_cnt = '0;
    end else if (frame_check_enable && chk_st.frame_end && frm_cnt != '1) begin
      next_frm_cnt = frm_cnt + 1'b1;
    end
    if (rx_error_count_read) begin
      next_frm_snap = frm_cnt;
    end
  end

  for (genvar i = 0; i < NUM_E; i++) begin : g_err
    always_comb begin
      next_err_cnt[i] = err_cnt[i];
      next_err_snap[i] = err_snap[i];
      if (fc_start) begin
        next_err_cnt[i] = '0;
      end else if (frame_check_enable && ev[i] && err_cnt[i] != '1) begin
        next_err_cnt[i] = err_cnt[i] + 1'b1;
      end
      if (rx_error_count_read) begin
        next_err_snap[i] = err_cnt[i];
      end
    end
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        err_cnt[i] <= '0;
        err_snap[i] <= '0;
      end else begin
        err_cnt[i] <= next_err_cnt[i];
        err_snap[i] <= next_err_snap[i];
      end
    end
    assign err_count_snap[i*CNT_W +: CNT_W] = err_snap[i];
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      frm_cnt <= '0;
      frm_snap <= '0;
      frame_check_enable_d <= 1'b0;
    end else begin
      frm_cnt <= next_frm_cnt;
      frm_snap <= next_frm_snap;
      frame_check_enable_d <= next_frame_check_enable_d;
    end
  end

  // live crc total; the read strobe freezes every snapshot at the same edge
  assign rx_error_count = err_cnt[plfg_pkg::E_CRC];
  assign frame_count_high = frm_snap[FRM_CNT_W-1:FRM_CNT_W/2];
  assign frame_count_low = frm_snap[FRM_CNT_W/2-1:0];
endmodule

// file: plfg_top_sva.sv
// assertion checker for the loopback, generator and checker block
`timescale 1ns/1ps
module plfg_top_sva #(
  parameter int CNT_W = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire plfg_pkg::plfg_loop_ctrl_t loop_ctrl,
  input wire logic link_up,
  input wire logic diag_clock_enable,
  input wire logic frame_gen_enable,
  input wire logic frame_gen_done,
  input wire logic frame_check_enable,
  input wire logic frame_check_source_select,
  input wire logic rx_error_count_read,
  input wire logic [CNT_W-1:0] rx_error_count,
  input wire logic [plfg_pkg::NUM_ERR*CNT_W-1:0] err_count_snap,
  input wire plfg_pkg::plfg_stream_t mac_tx_in,
  input wire plfg_pkg::plfg_stream_t mac_rx_out,
  input wire plfg_pkg::plfg_stream_t core_tx_out,
  input wire plfg_pkg::plfg_stream_t core_rx_in,
  input wire plfg_pkg::plfg_rx_status_t core_rx_status,
  input wire logic mdi_tx_enable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  pcs_tx_off_a: assert property (loop_ctrl.pcs_echo_enable |=> !mdi_tx_enable)
    else $error("medium driven during pcs echo");
  mac_echo_a: assert property ((loop_ctrl.mac_side_echo_enable || loop_ctrl.mac_echo_enable)
    && !loop_ctrl.mac_side_remote_echo_enable && mac_tx_in.valid |=> mac_rx_out == $past(mac_tx_in))
    else $error("mac data not echoed");
  tx_suppress_a: assert property (((loop_ctrl.mac_side_echo_enable && loop_ctrl.mac_side_tx_suppress)
    || loop_ctrl.mac_echo_enable) && !frame_gen_enable && !$past(frame_gen_enable)
    && !loop_ctrl.mac_side_remote_echo_enable |=> !core_tx_out.valid)
    else $error("echoed mac data reached core");
  remote_echo_a: assert property (loop_ctrl.mac_side_remote_echo_enable && link_up
    && core_rx_in.valid && !frame_gen_enable && !$past(frame_gen_enable)
    |=> core_tx_out == $past(core_rx_in)) else $error("remote echo wrong");
  rx_suppress_a: assert property (loop_ctrl.mac_side_remote_echo_enable && link_up
    && loop_ctrl.mac_side_rx_suppress && !loop_ctrl.mac_side_echo_enable
    && !loop_ctrl.mac_echo_enable |=> !mac_rx_out.valid) else $error("rx not suppressed");
  done_clear_a: assert property ($rose(frame_gen_enable) && diag_clock_enable
    |=> !frame_gen_done) else $error("done not cleared on start");
  crc_count_a: assert property (frame_check_enable && $past(frame_check_enable)
    && !frame_check_source_select && core_rx_status.frame_end && core_rx_status.crc_err
    && rx_error_count != '1 |=> rx_error_count == $past(rx_error_count) + 1'b1)
    else $error("crc count not advanced");
  snap_take_a: assert property (rx_error_count_read
    |=> err_count_snap[CNT_W-1:0] == $past(rx_error_count)) else $error("snapshot wrong");
  cover property (frame_gen_done);
  cover property (rx_error_count_read && rx_error_count != '0);
  cover property (loop_ctrl.mac_side_remote_echo_enable && core_tx_out.valid);
endmodule
bind plfg_top plfg_top_sva #(.CNT_W(CNT_W)) chk_u (
  .ref_clk(ref_clk), .rst(rst), .loop_ctrl(loop_ctrl), .link_up(link_up),
  .diag_clock_enable(diag_clock_enable), .frame_gen_enable(frame_gen_enable),
  .frame_gen_done(frame_gen_done), .frame_check_enable(frame_check_enable),
  .frame_check_source_select(frame_check_source_select),
  .rx_error_count_read(rx_error_count_read), .rx_error_count(rx_error_count),
  .err_count_snap(err_count_snap), .mac_tx_in(mac_tx_in), .mac_rx_out(mac_rx_out),
  .core_tx_out(core_tx_out), .core_rx_in(core_rx_in), .core_rx_status(core_rx_status),
  .mdi_tx_enable(mdi_tx_enable)
);

// file: plfg_far_phy.sv
// far-side phy model feeding frames into the receive path
`timescale 1ns/1ps
module plfg_far_phy (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic go,
  input wire logic crc_bad,
  input wire logic [3:0] len,
  output plfg_pkg::plfg_stream_t rx,
  output plfg_pkg::plfg_rx_status_t st
);
  logic [3:0] left;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      left <= 4'h0;
      rx <= '0;
      st <= '0;
    end else begin
      st <= '0;
      rx.valid <= 1'b0;
      rx.last <= 1'b0;
      // idle data keeps toggling so a stale value is never mistaken for data
      rx.data <= ~rx.data;
      if (go) begin
        left <= len;
      end else if (left != 4'h0) begin
        left <= left - 4'h1;
        rx <= '{1'b1, left == 4'h1, left};
        st.frame_end <= left == 4'h1;
        st.crc_err <= crc_bad && left == 4'h1;
      end
    end
  end
endmodule

// file: plfg_top_bench.sv
// self-checking bench for the loopback, generator and checker block
`timescale 1ns/1ps
module plfg_top_bench;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  plfg_pkg::plfg_loop_ctrl_t lc = '0;
  logic link_up = 1'b0;
  logic diag = 1'b0;
  plfg_pkg::plfg_gen_cfg_t cfg = '0;
  logic gen_en = 1'b0;
  logic chk_en = 1'b0;
  logic src = 1'b0;
  logic rd = 1'b0;
  logic go = 1'b0;
  logic bad = 1'b0;
  logic [3:0] len = 4'h3;
  plfg_pkg::plfg_stream_t mac_tx = '0;
  plfg_pkg::plfg_rx_status_t mac_st = '0;
  plfg_pkg::plfg_stream_t mac_rx, core_tx, core_rx;
  plfg_pkg::plfg_rx_status_t core_st;
  logic done, mdi_en, pma_m, pcs_m;
  logic [15:0] rx_err, fc_hi, fc_lo;
  logic [143:0] snap;
  int failures = 0;
  int samples_checked = 0;
  always #2 ref_clk = ~ref_clk;
  plfg_top dut_u (
    .ref_clk(ref_clk), .rst(rst), .loop_ctrl(lc), .link_up(link_up), .diag_clock_enable(diag),
    .gen_cfg(cfg), .frame_gen_enable(gen_en), .frame_gen_done(done),
    .frame_check_enable(chk_en), .frame_check_source_select(src), .rx_error_count_read(rd),
    .rx_error_count(rx_err), .frame_count_high(fc_hi), .frame_count_low(fc_lo),
    .err_count_snap(snap), .mac_tx_in(mac_tx), .mac_rx_out(mac_rx), .core_tx_out(core_tx),
    .core_rx_in(core_rx), .core_rx_status(core_st), .mac_rx_status(mac_st),
    .mdi_tx_enable(mdi_en), .pma_echo_mode(pma_m), .pcs_echo_mode(pcs_m));
  plfg_far_phy far_u (.ref_clk(ref_clk), .rst(rst), .go(go), .crc_bad(bad), .len(len),
    .rx(core_rx), .st(core_st));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic end_sim();
    if (failures == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic t_phy_loops();
    link_up = 1'b0;
    lc = '0;
    lc.pma_local_echo_enable = 1'b1;
    lc.pcs_echo_enable = 1'b1;
    cyc(2);
    chk({pma_m, pcs_m, mdi_en}, 3'h6);
    lc = '0;
    cyc(2);
    chk({pma_m, pcs_m, mdi_en}, 3'h1);
  endtask
  task automatic t_mac_loops();
    for (int m = 0; m < 3; m++) begin
      lc = '0;
      lc.mac_side_echo_enable = m != 1;
      lc.mac_side_tx_suppress = m == 0;
      lc.mac_echo_enable = m == 1;
      cyc(1);
      mac_tx = '{1'b1, 1'b1, 4'h5 + m[3:0]};
      cyc(1);
      chk(mac_rx, {2'h3, 4'h5 + m[3:0]});
      chk(core_tx, (m == 2) ? {2'h3, 4'h7} : 6'h0);
      mac_tx = '0;
    end
  endtask
  task automatic t_remote();
    int n;
    lc = '0;
    lc.mac_side_remote_echo_enable = 1'b1;
    lc.mac_side_rx_suppress = 1'b1;
    link_up = 1'b1;
    n = 0;
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    repeat (8) begin
      cyc(1);
      if (core_tx.valid === 1'b1) n++;
      if (mac_rx.valid === 1'b1) n += 16;
    end
    chk(n, len);
    lc = '0;
    link_up = 1'b0;
  endtask
  task automatic t_gen();
    int n;
    int l;
    logic [15:0] rl;
    cfg = '{2'h1, 16'h3, 16'h2};
    gen_en = 1'b1;
    cyc(8);
    chk(core_tx.valid, 1'b0);
    gen_en = 1'b0;
    mac_tx = '{1'b1, 1'b0, 4'h9};
    for (int p = 0; p < 4; p++) begin
      cfg.payload_type = p[1:0];
      diag = 1'b1;
      cyc(1);
      gen_en = 1'b1;
      n = 0;
      l = 0;
      rl = plfg_pkg::LFSR_SEED;
      for (int i = 0; i < 200 && (i == 0 || done !== 1'b1); i++) begin
        cyc(1);
        if (core_tx.valid === 1'b1) n++;
        if (core_tx.valid === 1'b1 && core_tx.last === 1'b1) l++;
        if (core_tx.valid === 1'b1 && p == 1) chk(core_tx.data, 4'hf);
        if (core_tx.valid === 1'b1 && p == 2) chk(core_tx.data, 4'h0);
        if (core_tx.valid === 1'b1 && p == 3) chk(core_tx.data, 4'((n - 1) % 3));
        if (core_tx.valid === 1'b1 && p == 0) begin
          chk(core_tx.data, rl[3:0]);
          rl = rl[0] ? ((rl >> 1) ^ plfg_pkg::LFSR_TAPS) : (rl >> 1);
        end
      end
      chk({n[7:0], l[7:0]}, 16'h0602);
      chk(done, 1'b1);
      if (done !== 1'b1) end_sim();
      gen_en = 1'b0;
    end
    mac_tx = '0;
    diag = 1'b0;
  endtask
  task automatic t_check();
    src = plfg_pkg::SRC_PHY;
    chk_en = 1'b1;
    for (int f = 0; f < 3; f++) begin
      bad = f == 1;
      go = 1'b1;
      cyc(1);
      go = 1'b0;
      cyc(5);
    end
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    cyc(1);
    chk(rx_err, 16'h1);
    chk(snap[15:0], 16'h1);
    chk({fc_hi, fc_lo}, 32'h3);
    src = plfg_pkg::SRC_MAC;
    chk_en = 1'b0;
    cyc(1);
    chk_en = 1'b1;
    cyc(1);
    mac_st = '1;
    cyc(1);
    mac_st = '0;
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    cyc(1);
    for (int s = 0; s < 9; s++) chk(snap[s*16 +: 16], 16'h1);
    chk({fc_hi, fc_lo}, 32'h1);
    mac_st.frame_end = 1'b1;
    mac_st.crc_err = 1'b1;
    cyc(65540);
    mac_st = '0;
    cyc(1);
    chk(rx_err, 16'hffff);
  endtask
  initial begin
    cyc(6);
    rst = 1'b0;
    cyc(1);
    t_phy_loops();
    t_mac_loops();
    t_remote();
    t_gen();
    t_check();
    end_sim();
  end
endmodule
